// *** core/clk_sel_top.sv ***
// Master, USB, soft-modem and programmable clock selection with an APB register file.
// Assumes all source clocks and event levels are synchronous to CLK_IN and much slower than it.
//
// Behaviour
// - Master source code 0 slow, 1 main, 2 PLL A choice, 3 UTMI PLL.
// - Halving bit 1 divides PLL A clock by two, 0 passes it undivided.
// - Master prescaler divides by 1..64 for codes 0..6 and by 3 for 7.
// - Master divider codes 0,1,2,3 divide prescaler output by 1,2,4,3.
// - DDR clock stops for divider code 0, else is prescaler output gated while the master divider count is below half its divisor.
// - Clock configuration registers ignore writes while write protect is enabled.
// - USB source bit picks PLL A clock for 0, UTMI PLL for 1.
// - USB clock is selected input divided by divider field plus one.
// - Modem source bit picks PLL A clock for 0, UTMI PLL for 1.
// - Modem clock is selected input divided by divider field plus one.
// - Programmable sources: slow, main, PLL A choice, UTMI, master for 0..4.
// - Programmable prescaler divides by 1..64 for codes 0..6; code 7 reserved.
// - Two programmable clocks, each with its own configuration register.
// - Enable port is write-only; ones enable sources, zeros change nothing.
// - Disable port is write-only; ones disable sources, zeros change nothing.
// - Sources: crystal, PLL A lock, master ready, UTMI lock, prog ready, selection, RC, failure.
// - Mask register reads one for each enabled source.
// - Clock failure flag set on failure, cleared by a status read.
`timescale 1ns/1ps
module clk_sel_top (
    input wire logic CLK_IN, // 250 MHz system clock
    input wire logic RESET_N_IN, // Asynchronous reset, active low
    input wire logic PSEL_IN, // APB select
    input wire logic PENABLE_IN, // APB enable
    input wire logic PWRITE_IN, // APB direction, high for write
    input wire logic [31:0] PADDR_IN, // APB byte address
    input wire logic [31:0] PWDATA_IN, // APB write data
    output logic [31:0] PRDATA_OUT, // APB read data
    output logic PREADY_OUT, // APB ready
    output logic PSLVERR_OUT, // APB error for unmapped address
    input wire logic SLOW_CLK_IN, // Slow clock level
    input wire logic MAIN_CLK_IN, // Main clock level
    input wire logic PLL_A_CLK_IN, // PLL A clock level
    input wire logic UTMI_CLK_IN, // UTMI PLL clock level
    input wire logic CRYSTAL_OSC_STABLE_IN, // Crystal oscillator stable
    input wire logic PLL_A_LOCKED_IN, // PLL A locked
    input wire logic UTMI_PLL_LOCKED_IN, // UTMI PLL locked
    input wire logic MAIN_OSC_SELECT_DONE_IN, // Main oscillator selection done
    input wire logic RC_OSC_STABLE_IN, // RC oscillator stable
    input wire logic CLOCK_FAILURE_IN, // Crystal failure detected
    output logic MASTER_CLOCK_OUT, // Master clock
    output logic DDR_CLOCK_OUT, // DDR clock
    output logic USB_CLOCK_OUT, // USB host clock
    output logic MODEM_CLOCK_OUT, // Soft-modem clock
    output logic [1:0] PROG_CLOCK_OUT, // Programmable clocks 0 and 1
    output logic IRQ_OUT // Interrupt, active high level
);
    import clk_sel_pkg::*;

    function automatic logic [6:0] prescaler_field_div(input logic [2:0] code, input logic allow_three);
        logic [6:0] n;
        n = DIV_ONE;
        if (code == PRESCALER_FIELD_DIV3) begin
            n = allow_three ? DIV_THREE : DIV_ONE;
        end else begin
            n = DIV_ONE << code;
        end
        return n;
    endfunction

    function automatic logic pick_src(input logic [2:0] code, input logic slow, input logic main,
                                      input logic plla, input logic utmi, input logic master);
        logic v;
        v = 1'b0;
        case (code)
            SRC_SLOW: v = slow;
            SRC_MAIN: v = main;
            SRC_PLLA: v = plla;
            SRC_UTMI: v = utmi;
            SRC_MASTER: v = master;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    logic rst_meta_r;
    logic rst_n;
    logic [31:0] mck_cfg_r;
    logic [31:0] usb_cfg_r;
    logic [31:0] modem_cfg_r;
    logic [31:0] prog_cfg_r [2];
    logic [31:0] status_r;
    logic [31:0] mask_r;
    logic write_protect_enable_r;
    logic [5:0] ev_prev_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic ddr_r;
    logic irq_r;
    logic [31:0] ev_pend_r;

    // Reset release through two flip-flops
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // APB decode: answer one cycle into the access phase
    wire apb_acc = PSEL_IN & PENABLE_IN & ~pready_r;
    wire apb_fire = PSEL_IN & PENABLE_IN & pready_r;
    wire wr_fire = apb_fire & PWRITE_IN;
    wire rd_fire = apb_fire & ~PWRITE_IN;
    wire hit_mck = PADDR_IN == MCK_CFG_ADDR;
    wire hit_usb = PADDR_IN == USB_CFG_ADDR;
    wire hit_modem = PADDR_IN == MODEM_CFG_ADDR;
    wire hit_p0 = PADDR_IN == PROG0_CFG_ADDR;
    wire hit_p1 = PADDR_IN == PROG1_CFG_ADDR;
    wire hit_ier = PADDR_IN == IRQ_EN_ADDR;
    wire hit_idr = PADDR_IN == IRQ_DIS_ADDR;
    wire hit_sr = PADDR_IN == STATUS_ADDR;
    wire hit_imr = PADDR_IN == MASK_ADDR;
    wire hit_wp = PADDR_IN == WP_MODE_ADDR;
    wire hit_any = hit_mck | hit_usb | hit_modem | hit_p0 | hit_p1 | hit_ier | hit_idr | hit_sr | hit_imr | hit_wp;
    wire cfg_ok = wr_fire & ~write_protect_enable_r;
    wire wr_mck = cfg_ok & hit_mck;
    wire wr_usb = cfg_ok & hit_usb;
    wire wr_modem = cfg_ok & hit_modem;
    wire [1:0] wr_prog = {cfg_ok & hit_p1, cfg_ok & hit_p0};
    wire key_ok = PWDATA_IN[WP_KEY_LSB +: 24] == WP_KEY;

    // Enable and disable ports read as zero; key field reads as zero
    wire [31:0] rd_mux = hit_mck ? mck_cfg_r :
                         hit_usb ? usb_cfg_r :
                         hit_modem ? modem_cfg_r :
                         hit_p0 ? prog_cfg_r[0] :
                         hit_p1 ? prog_cfg_r[1] :
                         hit_sr ? status_r :
                         hit_imr ? mask_r :
                         hit_wp ? {31'h0, write_protect_enable_r} : 32'h0;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= apb_acc;
            pslverr_r <= apb_acc & ~hit_any;
            prdata_r <= (apb_acc && !PWRITE_IN) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            mck_cfg_r <= MCK_RESET;
            usb_cfg_r <= CFG_RESET;
            modem_cfg_r <= CFG_RESET;
            prog_cfg_r[0] <= CFG_RESET;
            prog_cfg_r[1] <= CFG_RESET;
            write_protect_enable_r <= 1'b0;
        end else begin
            if (wr_mck) mck_cfg_r <= PWDATA_IN & MCK_WMASK;
            if (wr_usb) usb_cfg_r <= PWDATA_IN & USB_WMASK;
            if (wr_modem) modem_cfg_r <= PWDATA_IN & MODEM_WMASK;
            if (wr_prog[0]) prog_cfg_r[0] <= PWDATA_IN & PROG_WMASK;
            if (wr_prog[1]) prog_cfg_r[1] <= PWDATA_IN & PROG_WMASK;
            if (wr_fire && hit_wp && key_ok) write_protect_enable_r <= PWDATA_IN[WRITE_PROTECT_ENABLE_BIT];
        end
    end

    // Rising edges of external levels and accepted master and programmable clock writes become status events
    wire [5:0] ev_lvl = {CLOCK_FAILURE_IN, RC_OSC_STABLE_IN, MAIN_OSC_SELECT_DONE_IN,
                         UTMI_PLL_LOCKED_IN, PLL_A_LOCKED_IN, CRYSTAL_OSC_STABLE_IN};
    wire [5:0] ev_rise = ev_lvl & ~ev_prev_r;
    wire [31:0] ev_set = ev_pend_r | ((32'(ev_rise[0]) << IRQ_CRYSTAL) | (32'(ev_rise[1]) << IRQ_PLLA)
                         | (32'(ev_rise[2]) << IRQ_UTMI) | (32'(ev_rise[3]) << IRQ_MOSCSEL)
                         | (32'(ev_rise[4]) << IRQ_RC) | (32'(ev_rise[5]) << IRQ_CFD));
    wire [31:0] wr_ev = (32'(wr_mck) << IRQ_MASTER_CLOCK_READY) | (32'(wr_prog[0]) << IRQ_PCK0)
                        | (32'(wr_prog[1]) << IRQ_PCK1);
    wire [31:0] sr_w1c = (wr_fire && hit_sr) ? (PWDATA_IN & IRQ_ALL) : 32'h0;
    wire [31:0] sr_rdc = (rd_fire && hit_sr) ? (32'h1 << IRQ_CFD) : 32'h0;
    wire [31:0] status_nxt = ((status_r & ~sr_w1c & ~sr_rdc) | ev_set) & IRQ_ALL;
    wire [31:0] mask_nxt = ((mask_r | (hit_ier ? PWDATA_IN : 32'h0)) & ~(hit_idr ? PWDATA_IN : 32'h0)) & IRQ_ALL;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ev_prev_r <= 6'h0;
            ev_pend_r <= 32'h0;
            status_r <= 32'h0;
            mask_r <= 32'h0;
            irq_r <= 1'b0;
        end else begin
            ev_prev_r <= ev_lvl;
            ev_pend_r <= wr_ev; // Ready flags follow the accepted write by one cycle
            status_r <= status_nxt;
            if (wr_fire) mask_r <= mask_nxt;
            irq_r <= |(status_r & mask_r);
        end
    end

    // Divider chain: 0 PLL A halving, 1 master prescaler, 2 master divider,
    // 3 USB, 4 modem, 5 and 6 programmable clocks
    logic [NUM_DIV-1:0] div_in;
    logic [NUM_DIV-1:0] div_out;
    logic [6:0] div_n [NUM_DIV];
    wire [1:0] master_divider_field = mck_cfg_r[MASTER_DIVIDER_FIELD_LSB +: 2];
    wire [2:0] mck_css = {1'b0, mck_cfg_r[CSS_LSB +: 2]};
    wire [2:0] mck_prescaler_field = mck_cfg_r[PRESCALER_FIELD_LSB +: 3];
    wire pll_a_choice = div_out[0];
    wire master_choice = div_out[2];

    assign div_in[0] = PLL_A_CLK_IN;
    assign div_n[0] = mck_cfg_r[HALVE_BIT] ? DIV_TWO : DIV_ONE;
    assign div_in[1] = pick_src(mck_css, SLOW_CLK_IN, MAIN_CLK_IN, pll_a_choice, UTMI_CLK_IN, 1'b0);
    assign div_n[1] = prescaler_field_div(mck_prescaler_field, 1'b1);
    assign div_in[2] = div_out[1];
    assign div_n[2] = (master_divider_field == 2'h0) ? DIV_ONE : (master_divider_field == 2'h1) ? DIV_TWO :
                      (master_divider_field == 2'h2) ? DIV_FOUR : DIV_THREE;
    assign div_in[3] = usb_cfg_r[SRC_BIT] ? UTMI_CLK_IN : PLL_A_CLK_IN;
    assign div_n[3] = {3'h0, usb_cfg_r[AUX_DIV_LSB +: 4]} + DIV_ONE;
    assign div_in[4] = modem_cfg_r[SRC_BIT] ? UTMI_CLK_IN : PLL_A_CLK_IN;
    assign div_n[4] = {2'h0, modem_cfg_r[AUX_DIV_LSB +: 5]} + DIV_ONE;

    for (genvar p = 0; p < 2; p++) begin : g_prog
        assign div_in[5 + p] = pick_src(prog_cfg_r[p][CSS_LSB +: 3], SLOW_CLK_IN, MAIN_CLK_IN,
                                        pll_a_choice, UTMI_CLK_IN, master_choice);
        assign div_n[5 + p] = prescaler_field_div(prog_cfg_r[p][PRESCALER_FIELD_LSB +: 3], 1'b0);
    end

    // Each stage counts input rising edges; output follows the input when dividing by one, else is high while the count is below half the divisor
    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
        logic prev_r;
        logic out_r;
        logic [6:0] cnt_r;
        wire rise = div_in[i] & ~prev_r;
        wire [6:0] cnt_nxt = (cnt_r >= div_n[i] - DIV_ONE) ? 7'h0 : cnt_r + DIV_ONE;
        always_ff @(posedge CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
                prev_r <= 1'b0;
                out_r <= 1'b0;
                cnt_r <= 7'h0;
            end else begin
                prev_r <= div_in[i];
                if (rise) cnt_r <= cnt_nxt;
                out_r <= (div_n[i] == DIV_ONE) ? div_in[i] : (cnt_r < (div_n[i] >> 1));
            end
        end
        assign div_out[i] = out_r;
    end

    wire cnt_zero_ddr = (div_n[2] == DIV_ONE) | (g_div[2].cnt_r < (div_n[2] >> 1));
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ddr_r <= 1'b0;
        end else begin
            ddr_r <= (master_divider_field != 2'h0) & div_in[2] & (cnt_zero_ddr);
        end
    end

    assign PRDATA_OUT = prdata_r;
    assign PREADY_OUT = pready_r;
    assign PSLVERR_OUT = pslverr_r;
    assign MASTER_CLOCK_OUT = div_out[2];
    assign DDR_CLOCK_OUT = ddr_r;
    assign USB_CLOCK_OUT = div_out[3];
    assign MODEM_CLOCK_OUT = div_out[4];
    assign PROG_CLOCK_OUT = div_out[6:5];
    assign IRQ_OUT = irq_r;

    // Checks
    sequence s_cfg_write_blocked;
        wr_fire && hit_mck && write_protect_enable_r;
    endsequence

    wp_block_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        s_cfg_write_blocked |=> $stable(mck_cfg_r)) else $error("protected write changed master config");

    ier_set_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (wr_fire && hit_ier) |=> ((mask_r & $past(PWDATA_IN) & IRQ_ALL) == ($past(PWDATA_IN) & IRQ_ALL)))
        else $error("enable port did not set mask bits");

    idr_clr_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (wr_fire && hit_idr) |=> ((mask_r & $past(PWDATA_IN)) == 32'h0)
            && ((mask_r | $past(PWDATA_IN)) == ($past(mask_r) | $past(PWDATA_IN))))
        else $error("disable port mask update wrong");

    irq_level_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        ((status_r & mask_r) != 32'h0) ##1 ((status_r & mask_r) != 32'h0) |-> IRQ_OUT)
        else $error("interrupt low while enabled flag set");

    cfd_clear_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (rd_fire && hit_sr && !ev_set[IRQ_CFD]) |=> !status_r[IRQ_CFD])
        else $error("failure flag survived status read");

    ddr_off_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (master_divider_field == 2'h0) [*2] |-> !DDR_CLOCK_OUT) else $error("DDR clock running with divider code 0");

    mck_pass_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (mck_prescaler_field == 3'h0 && master_divider_field == 2'h0) [*3] |-> MASTER_CLOCK_OUT == $past(div_in[1], 2))
        else $error("undivided master clock does not follow its source");

    halve_off_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        !mck_cfg_r[HALVE_BIT] [*2] |-> pll_a_choice == $past(PLL_A_CLK_IN))
        else $error("PLL A clock not passed undivided");

    usb_src_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (usb_cfg_r == 32'h1) [*2] |-> USB_CLOCK_OUT == $past(UTMI_CLK_IN))
        else $error("USB clock not from UTMI PLL");

    sticky_set_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        (ev_set != 32'h0) |=> ((status_r & $past(ev_set)) == $past(ev_set)))
        else $error("status event lost");
endmodule // clk_sel_top

// *** core/clk_sel_pkg.sv ***
// Package of the master and auxiliary clock selection block.
// Holds register byte addresses, field positions, write masks, reset values and codes.
package clk_sel_pkg;
    localparam logic [31:0] MCK_CFG_ADDR = 32'h0ffffc30;
    localparam logic [31:0] USB_CFG_ADDR = 32'h0ffffc38;
    localparam logic [31:0] MODEM_CFG_ADDR = 32'h0ffffc3c;
    localparam logic [31:0] PROG0_CFG_ADDR = 32'h0ffffc40;
    localparam logic [31:0] PROG1_CFG_ADDR = 32'h0ffffc44;
    localparam logic [31:0] IRQ_EN_ADDR = 32'h0ffffc60;
    localparam logic [31:0] IRQ_DIS_ADDR = 32'h0ffffc64;
    localparam logic [31:0] STATUS_ADDR = 32'h0ffffc68;
    localparam logic [31:0] MASK_ADDR = 32'h0ffffc6c;
    localparam logic [31:0] WP_MODE_ADDR = 32'h0ffffce4;
    // Field positions
    localparam int CSS_LSB = 0;
    localparam int PRESCALER_FIELD_LSB = 4;
    localparam int MASTER_DIVIDER_FIELD_LSB = 8;
    localparam int HALVE_BIT = 12;
    localparam int SRC_BIT = 0;
    localparam int AUX_DIV_LSB = 8;
    localparam int WP_KEY_LSB = 8;
    localparam int WRITE_PROTECT_ENABLE_BIT = 0;
    // Writable bits of each register
    localparam logic [31:0] MCK_WMASK = 32'h00001373;
    localparam logic [31:0] USB_WMASK = 32'h00000f01;
    localparam logic [31:0] MODEM_WMASK = 32'h00001f01;
    localparam logic [31:0] PROG_WMASK = 32'h00000077;
    localparam logic [31:0] MCK_RESET = 32'h00000001;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [23:0] WP_KEY = 24'h504d43;
    // Interrupt source bits
    localparam int IRQ_CRYSTAL = 0;
    localparam int IRQ_PLLA = 1;
    localparam int IRQ_MASTER_CLOCK_READY = 3;
    localparam int IRQ_UTMI = 6;
    localparam int IRQ_PCK0 = 8;
    localparam int IRQ_PCK1 = 9;
    localparam int IRQ_MOSCSEL = 16;
    localparam int IRQ_RC = 17;
    localparam int IRQ_CFD = 18;
    localparam logic [31:0] IRQ_ALL = 32'h0007034b;
    // Source select codes
    localparam logic [2:0] SRC_SLOW = 3'h0;
    localparam logic [2:0] SRC_MAIN = 3'h1;
    localparam logic [2:0] SRC_PLLA = 3'h2;
    localparam logic [2:0] SRC_UTMI = 3'h3;
    localparam logic [2:0] SRC_MASTER = 3'h4;
    localparam logic [2:0] PRESCALER_FIELD_DIV3 = 3'h7;
    localparam logic [6:0] DIV_ONE = 7'h01;
    localparam logic [6:0] DIV_TWO = 7'h02;
    localparam logic [6:0] DIV_THREE = 7'h03;
    localparam logic [6:0] DIV_FOUR = 7'h04;
    localparam int NUM_DIV = 7;
endpackage

// *** testbench/testbench.sv ***
// Self-checking bench for the clock selection block: APB register access, protection, interrupts, clock rates.
// Assumes clk_sel_pkg and clk_sel_top are compiled first; source clocks are made here from CLK_IN.
`timescale 1ns/1ps
module testbench;
    import clk_sel_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic slow = 1'b0, main_c = 1'b0, plla = 1'b0, utmi = 1'b0;
    logic crys = 1'b0, lock_a = 1'b0, lock_u = 1'b0, msel = 1'b0, rc = 1'b0, cfail = 1'b0;
    logic mclk, ddr, usbc, modem, irq;
    logic [1:0] prog;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int m3 = 0;

    clk_sel_top clk_sel_top_inst (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .SLOW_CLK_IN(slow), .MAIN_CLK_IN(main_c), .PLL_A_CLK_IN(plla),
        .UTMI_CLK_IN(utmi), .CRYSTAL_OSC_STABLE_IN(crys), .PLL_A_LOCKED_IN(lock_a),
        .UTMI_PLL_LOCKED_IN(lock_u), .MAIN_OSC_SELECT_DONE_IN(msel), .RC_OSC_STABLE_IN(rc),
        .CLOCK_FAILURE_IN(cfail), .MASTER_CLOCK_OUT(mclk), .DDR_CLOCK_OUT(ddr), .USB_CLOCK_OUT(usbc),
        .MODEM_CLOCK_OUT(modem), .PROG_CLOCK_OUT(prog), .IRQ_OUT(irq)
    );

    always #2 clk = ~clk;

    // Source clocks: slow period 16, main 2, PLL A 4, UTMI 6 cycles; also the run ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        slow <= cyc[3];
        main_c <= cyc[0];
        plla <= cyc[1];
        m3 <= (m3 == 2) ? 0 : m3 + 1;
        if (m3 == 2) begin
            utmi <= ~utmi;
        end
        if (cyc == 60000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    // Period in CLK_IN cycles between the second and third rising edge; 0 if the clock is stopped
    task automatic step(input logic [31:0] a, input logic [31:0] d, input int s, input int exp);
        int n, k, last, p;
        logic b, prv;
        wr(a, d);
        repeat (300) @(posedge clk);
        k = 0;
        last = 0;
        p = 0;
        prv = 1'b1;
        for (n = 0; n < 600 && k < 3; n++) begin
            @(posedge clk);
            case (s)
                0: b = mclk;
                1: b = ddr;
                2: b = usbc;
                3: b = modem;
                4: b = prog[0];
                default: b = prog[1];
            endcase
            if (b === 1'b1 && prv === 1'b0) begin
                if (k > 0) p = n - last;
                last = n;
                k++;
            end
            prv = b;
        end
        check(32'(p), 32'(exp));
    endtask

    task automatic test_regs;
        logic [31:0] r;
        logic e;
        rd(MCK_CFG_ADDR, MCK_RESET);
        rd(USB_CFG_ADDR, CFG_RESET);
        rd(MODEM_CFG_ADDR, CFG_RESET);
        rd(PROG1_CFG_ADDR, CFG_RESET);
        rd(MASK_ADDR, 32'h0);
        apb(1'b0, 32'h0ffffc34, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
        wr(USB_CFG_ADDR, 32'hffffffff);
        rd(USB_CFG_ADDR, USB_WMASK);
        wr(MODEM_CFG_ADDR, 32'hffffffff);
        rd(MODEM_CFG_ADDR, MODEM_WMASK);
        wr(PROG1_CFG_ADDR, 32'hffffffff);
        rd(PROG1_CFG_ADDR, PROG_WMASK);
        rd(PROG0_CFG_ADDR, CFG_RESET);
        wr(MCK_CFG_ADDR, 32'hffffffff);
        rd(MCK_CFG_ADDR, MCK_WMASK);
        $display("test_regs finished");
    endtask

    task automatic test_protect;
        wr(MCK_CFG_ADDR, 32'h1);
        wr(WP_MODE_ADDR, {WP_KEY, 8'h01});
        rd(WP_MODE_ADDR, 32'h1);
        wr(MCK_CFG_ADDR, 32'h2);
        wr(USB_CFG_ADDR, 32'h0);
        wr(PROG1_CFG_ADDR, 32'h0);
        rd(MCK_CFG_ADDR, 32'h1);
        rd(USB_CFG_ADDR, USB_WMASK);
        rd(PROG1_CFG_ADDR, PROG_WMASK);
        wr(WP_MODE_ADDR, {24'h123456, 8'h00});
        rd(WP_MODE_ADDR, 32'h1);
        wr(WP_MODE_ADDR, {WP_KEY, 8'h00});
        wr(MCK_CFG_ADDR, 32'h2);
        rd(MCK_CFG_ADDR, 32'h2);
        $display("test_protect finished");
    endtask

    task automatic test_irq;
        logic [31:0] r;
        logic e;
        wr(IRQ_EN_ADDR, 32'h00040001);
        rd(MASK_ADDR, 32'h00040001);
        @(posedge clk);
        crys <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(IRQ_DIS_ADDR, 32'h00000001);
        wr(IRQ_EN_ADDR, 32'h0);
        rd(MASK_ADDR, 32'h00040000);
        rd(IRQ_DIS_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        cfail <= 1'b1;
        repeat (6) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, STATUS_ADDR, 32'h0, r, e);
        check(r & 32'h00040001, 32'h00040001);
        apb(1'b0, STATUS_ADDR, 32'h0, r, e);
        check(r & 32'h00040000, 32'h0);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        lock_a <= 1'b1;
        lock_u <= 1'b1;
        msel <= 1'b1;
        rc <= 1'b1;
        wr(IRQ_EN_ADDR, IRQ_ALL);
        rd(MASK_ADDR, IRQ_ALL);
        apb(1'b0, STATUS_ADDR, 32'h0, r, e);
        check(r & 32'h00030043, 32'h00030043);
        wr(STATUS_ADDR, IRQ_ALL);
        rd(STATUS_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(IRQ_DIS_ADDR, IRQ_ALL);
        rd(MASK_ADDR, 32'h0);
        $display("test_irq finished");
    endtask

    task automatic test_clocks;
        step(MCK_CFG_ADDR, 32'h0000, 0, 16);
        step(MCK_CFG_ADDR, 32'h0001, 0, 2);
        step(MCK_CFG_ADDR, 32'h0002, 0, 4);
        step(MCK_CFG_ADDR, 32'h1002, 0, 8);
        step(MCK_CFG_ADDR, 32'h0003, 0, 6);
        step(MCK_CFG_ADDR, 32'h0011, 0, 4);
        step(MCK_CFG_ADDR, 32'h0041, 0, 32);
        step(MCK_CFG_ADDR, 32'h0061, 0, 128);
        step(MCK_CFG_ADDR, 32'h0071, 0, 6);
        step(MCK_CFG_ADDR, 32'h0101, 0, 4);
        step(MCK_CFG_ADDR, 32'h0201, 0, 8);
        step(MCK_CFG_ADDR, 32'h0301, 1, 6);
        step(MCK_CFG_ADDR, 32'h0001, 1, 0);
        step(MCK_CFG_ADDR, 32'h0021, 0, 8);
        step(USB_CFG_ADDR, 32'h0001, 2, 6);
        step(USB_CFG_ADDR, 32'h0201, 2, 6 * 3);
        step(USB_CFG_ADDR, 32'h0200, 2, 4 * 3);
        step(MODEM_CFG_ADDR, 32'h0401, 3, 6 * 5);
        step(MODEM_CFG_ADDR, 32'h0000, 3, 4);
        step(PROG0_CFG_ADDR, 32'h0010, 4, 32);
        step(PROG0_CFG_ADDR, 32'h0012, 4, 8);
        step(PROG0_CFG_ADDR, 32'h0014, 4, 16);
        step(PROG0_CFG_ADDR, 32'h0061, 4, 128);
        step(PROG1_CFG_ADDR, 32'h0023, 5, 24);
        $display("test_clocks finished");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_regs();
        test_protect();
        test_irq();
        test_clocks();
        conclude();
    end
endmodule // testbench
